// >>> src/mscp_pkg.sv
`default_nettype none

package mscp_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WAKE_PULSE_MS = 100;
  localparam int unsigned WAKE_PULSE_CYC = (CLK_HZ / 1000) * WAKE_PULSE_MS;

  // ==========================================================================
  // Field widths and reset values
  // ==========================================================================
  localparam int unsigned PWR_W = 8;
  localparam logic [7:0] PWR_THRESH_RST = 8'h10;
  localparam logic [7:0] PWR_DEFAULT_RST = 8'hff;
  localparam logic [1:0] ANT_SEL_RST = 2'h0;
  localparam logic FLIGHT_RST = 1'b0;
  localparam logic RADIO_EN_RST = 1'b1;
  localparam logic CAPPED_RST = 1'b0;
  localparam logic RADIO_OFF_CMD_RST = 1'b0;
  // Pins idle high, so a floating pin reads as released
  localparam logic PIN_IDLE_LVL = 1'b1;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic call_in;
    logic sms_in;
    logic data_req;
  } mscp_wake_src_t;

  typedef struct packed {
    logic radio_off_set;
    logic radio_off_val;
    logic thresh_set;
    logic [7:0] thresh_val;
    logic ant_set;
    logic [1:0] ant_val;
  } mscp_cmd_t;

  typedef struct packed {
    logic flight_mode;
    logic radio_enable;
    logic power_capped;
    logic [7:0] tx_power_limit;
  } mscp_status_t;

endpackage

`default_nettype wire

// >>> src/mscp_status_pins.sv
`timescale 1ns/1ps
`default_nettype none

module mscp_status_pins #(
  parameter int unsigned WAKE_CYC = mscp_pkg::WAKE_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire mscp_pkg::mscp_wake_src_t wake_src,
  input wire logic gsm_band_active,
  input wire logic gsm_tx_burst,
  input wire logic radio_disable_n,
  input wire logic proximity_detect_n,
  input wire mscp_pkg::mscp_cmd_t cmd,
  input wire logic [7:0] default_power,
  output logic host_wake_out,
  output logic tx_burst_blank_out,
  output logic antenna_switch_sel0,
  output logic antenna_switch_sel1,
  output mscp_pkg::mscp_status_t status
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  localparam int unsigned CNT_W = $clog2(WAKE_CYC + 1);

  if (WAKE_CYC < 1)
  begin : g_bad_wake
    $error("WAKE_CYC must be at least one");
  end

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic radio_dis_n_s;
  logic prox_n_s;

  // Idle high, so floating pins read as released
  mscp_sync #(
    .RST_VAL(mscp_pkg::PIN_IDLE_LVL)
  ) u_sync_radio (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(radio_disable_n),
    .sync_out(radio_dis_n_s)
  );

  mscp_sync #(
    .RST_VAL(mscp_pkg::PIN_IDLE_LVL)
  ) u_sync_prox (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(proximity_detect_n),
    .sync_out(prox_n_s)
  );

  // ==========================================================================
  // Host wake pulse
  // ==========================================================================
  logic wake_event;
  logic [CNT_W-1:0] wake_cnt_q;

  assign wake_event = wake_src.call_in | wake_src.sms_in | wake_src.data_req;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wake_cnt_q <= '0;
    end
    else if (wake_event)
    begin
      wake_cnt_q <= CNT_W'(WAKE_CYC);
    end
    else if (wake_cnt_q != '0)
    begin
      wake_cnt_q <= wake_cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      host_wake_out <= 1'b0;
    end
    else
    begin
      // High exactly WAKE_CYC cycles after the last event
      host_wake_out <= wake_event | (wake_cnt_q > CNT_W'(1));
    end
  end

  // ==========================================================================
  // Burst blanking
  // ==========================================================================
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tx_burst_blank_out <= 1'b0;
    end
    else
    begin
      tx_burst_blank_out <= gsm_band_active & gsm_tx_burst;
    end
  end

  // ==========================================================================
  // Host command settings
  // ==========================================================================
  logic cmd_radio_off_q;
  logic [7:0] thresh_q;
  logic [1:0] ant_sel_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cmd_radio_off_q <= mscp_pkg::RADIO_OFF_CMD_RST;
    end
    else if (cmd.radio_off_set)
    begin
      cmd_radio_off_q <= cmd.radio_off_val;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      thresh_q <= mscp_pkg::PWR_THRESH_RST;
    end
    else if (cmd.thresh_set)
    begin
      thresh_q <= cmd.thresh_val;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ant_sel_q <= mscp_pkg::ANT_SEL_RST;
    end
    else if (cmd.ant_set)
    begin
      ant_sel_q <= cmd.ant_val;
    end
  end

  assign antenna_switch_sel0 = ant_sel_q[0];
  assign antenna_switch_sel1 = ant_sel_q[1];

  // ==========================================================================
  // Radio state and power limit
  // ==========================================================================
  logic [7:0] cap_d;
  logic flight_q;
  logic radio_en_q;
  logic capped_q;
  logic [7:0] pwr_limit_q;

  // A threshold above the default would raise power, so take the lower
  assign cap_d = (thresh_q < default_power) ? thresh_q : default_power;

  // Pin low or command off: flight mode
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      flight_q <= mscp_pkg::FLIGHT_RST;
    end
    else
    begin
      flight_q <= !radio_dis_n_s | cmd_radio_off_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      radio_en_q <= mscp_pkg::RADIO_EN_RST;
    end
    else
    begin
      radio_en_q <= radio_dis_n_s & !cmd_radio_off_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      capped_q <= mscp_pkg::CAPPED_RST;
    end
    else
    begin
      capped_q <= !prox_n_s;
    end
  end

  // Same sync stage as the capped flag, so both move on one edge
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      pwr_limit_q <= mscp_pkg::PWR_DEFAULT_RST;
    end
    else if (!prox_n_s)
    begin
      pwr_limit_q <= cap_d;
    end
    else
    begin
      pwr_limit_q <= default_power;
    end
  end

  assign status = '{flight_mode: flight_q, radio_enable: radio_en_q, power_capped: capped_q,
                    tx_power_limit: pwr_limit_q};

endmodule

`default_nettype wire

// >>> src/mscp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two-stage synchroniser, reset to a chosen idle level
// ============================================================================
module mscp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/mscp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Host side and proximity sensor
module mscp_host_model (
  input wire logic sys_clk,
  input wire logic body_near,
  input wire logic tx_burst_blank_out,
  output logic proximity_detect_n,
  output logic gps_hold
);
  // Pull-up idles high, sensor pulls low
  assign proximity_detect_n = body_near ? 1'b0 : 1'b1;
  always_ff @(posedge sys_clk)
    gps_hold <= tx_burst_blank_out;
endmodule
`default_nettype wire

// >>> testbench/mscp_status_pins_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mscp_status_pins_sva #(
  parameter int unsigned WAKE_CYC = mscp_pkg::WAKE_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire mscp_pkg::mscp_wake_src_t wake_src,
  input wire logic gsm_band_active,
  input wire logic gsm_tx_burst,
  input wire logic radio_disable_n,
  input wire logic proximity_detect_n,
  input wire mscp_pkg::mscp_cmd_t cmd,
  input wire logic [7:0] default_power,
  input wire logic host_wake_out,
  input wire logic tx_burst_blank_out,
  input wire logic antenna_switch_sel0,
  input wire logic antenna_switch_sel1,
  input wire mscp_pkg::mscp_status_t status
);
  // ======
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic blank_cond;
  logic [1:0] ant_pins;
  logic capped;
  logic [7:0] lim;
  assign blank_cond = gsm_band_active && gsm_tx_burst;
  assign ant_pins = {antenna_switch_sel1, antenna_switch_sel0};
  assign capped = status.power_capped;
  assign lim = status.tx_power_limit;
  // Age since last wake event, zero when idle
  logic [31:0] age_q;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      age_q <= 32'h0;
    else if (|wake_src)
      age_q <= 32'h1;
    else if (age_q != 32'h0 && age_q <= WAKE_CYC)
      age_q <= age_q + 32'h1;
    else
      age_q <= 32'h0;
  end
  sequence s_radio_off;
    cmd.radio_off_set && cmd.radio_off_val;
  endsequence
  a_wake_rise: assert property (|wake_src |=> host_wake_out)
    else $error("wake missing");
  a_wake_len: assert property (host_wake_out == (age_q != 32'h0 && age_q <= WAKE_CYC))
    else $error("wake length");
  a_blank_step: assert property (1'b1 |=> tx_burst_blank_out == $past(blank_cond))
    else $error("blank");
  a_flight_pin: assert property (!radio_disable_n |-> ##3 status.flight_mode)
    else $error("pin flight");
  a_flight_cmd: assert property (s_radio_off |-> ##2 status.flight_mode)
    else $error("cmd flight");
  a_radio_pair: assert property (status.radio_enable != status.flight_mode)
    else $error("radio pair");
  a_cap_on: assert property (!proximity_detect_n |-> ##3 status.power_capped)
    else $error("cap on");
  a_cap_off: assert property (proximity_detect_n |-> ##3 !status.power_capped)
    else $error("cap off");
  a_ant_sel: assert property (cmd.ant_set |=> ant_pins == $past(cmd.ant_val))
    else $error("ant sel");
  a_limit_free: assert property (1'b1 |=> capped || lim == $past(default_power))
    else $error("limit free");
  a_limit_cap: assert property (1'b1 |=> !capped || lim <= $past(default_power))
    else $error("limit cap");
endmodule
bind mscp_status_pins mscp_status_pins_sva #(.WAKE_CYC(WAKE_CYC)) i_sva (.sys_clk(sys_clk),
  .resetn(resetn), .wake_src(wake_src), .gsm_band_active(gsm_band_active),
  .gsm_tx_burst(gsm_tx_burst), .radio_disable_n(radio_disable_n),
  .proximity_detect_n(proximity_detect_n), .cmd(cmd), .default_power(default_power),
  .host_wake_out(host_wake_out),
  .tx_burst_blank_out(tx_burst_blank_out), .antenna_switch_sel0(antenna_switch_sel0),
  .antenna_switch_sel1(antenna_switch_sel1), .status(status));
`default_nettype wire

// >>> testbench/mscp_status_pins_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mscp_status_pins_tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic band = 1'b0, burst = 1'b0, rdis_n = 1'b1, near = 1'b0;
  logic [7:0] dpow = 8'hff;
  mscp_pkg::mscp_wake_src_t wake_src = '0;
  mscp_pkg::mscp_cmd_t cmd = '0;
  mscp_pkg::mscp_cmd_t c;
  mscp_pkg::mscp_status_t st;
  wire prox_n, wake, blank, sel0, sel1, gps_hold;
  int num_errors = 0;
  int total_checks = 0;
  initial forever #5 sys_clk = ~sys_clk;
  // Short pulse keeps the run brief
  mscp_status_pins #(.WAKE_CYC(20)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .wake_src(wake_src), .gsm_band_active(band), .gsm_tx_burst(burst),
    .radio_disable_n(rdis_n), .proximity_detect_n(prox_n), .cmd(cmd),
    .default_power(dpow), .host_wake_out(wake), .tx_burst_blank_out(blank),
    .antenna_switch_sel0(sel0), .antenna_switch_sel1(sel1), .status(st));
  mscp_host_model i_host (.sys_clk(sys_clk), .body_near(near),
    .tx_burst_blank_out(blank), .proximity_detect_n(prox_n), .gps_hold(gps_hold));
  // ======
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input mscp_pkg::mscp_cmd_t v);
    cmd = v;
    tick(1);
    cmd = '0;
    tick(1);
  endtask
  task automatic pulse(input int i);
    wake_src = mscp_pkg::mscp_wake_src_t'(3'h4 >> i);
    tick(1);
    wake_src = '0;
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ======
  // Sequence
  initial
  begin
    tick(12);
    resetn = 1'b1;
    tick(1);
    chk(8'(wake), 8'h0);
    chk(st.tx_power_limit, 8'hff);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      chk(8'(wake), 8'h1);
      tick(19);
      chk(8'(wake), 8'h1);
      tick(1);
      chk(8'(wake), 8'h0);
    end
    pulse(0);
    tick(10);
    pulse(1);
    tick(19);
    chk(8'(wake), 8'h1);
    tick(1);
    chk(8'(wake), 8'h0);
    for (int j = 0; j < 4; j++)
    begin
      {band, burst} = 2'(j);
      tick(1);
      chk(8'(blank), 8'(j == 3));
    end
    chk(8'(gps_hold), 8'h0);
    tick(1);
    chk(8'(gps_hold), 8'h1);
    rdis_n = 1'b0;
    tick(3);
    chk(8'(st.flight_mode), 8'h1);
    chk(8'(st.radio_enable), 8'h0);
    rdis_n = 1'b1;
    tick(3);
    chk(8'(st.radio_enable), 8'h1);
    chk(8'(st.flight_mode), 8'h0);
    c = '0;
    c.radio_off_set = 1'b1;
    c.radio_off_val = 1'b1;
    send(c);
    chk(8'(st.flight_mode), 8'h1);
    c.radio_off_val = 1'b0;
    send(c);
    chk(8'(st.flight_mode), 8'h0);
    dpow = 8'h80;
    near = 1'b1;
    tick(3);
    chk(8'(st.power_capped), 8'h1);
    chk(st.tx_power_limit, 8'h10);
    c = '0;
    c.thresh_set = 1'b1;
    c.thresh_val = 8'h40;
    send(c);
    chk(st.tx_power_limit, 8'h40);
    c.thresh_val = 8'hc0;
    send(c);
    chk(st.tx_power_limit, 8'h80);
    near = 1'b0;
    tick(3);
    chk(8'(st.power_capped), 8'h0);
    chk(st.tx_power_limit, 8'h80);
    c = '0;
    c.ant_set = 1'b1;
    for (int v = 0; v < 4; v++)
    begin
      c.ant_val = 2'(v);
      send(c);
      chk(8'({sel1, sel0}), 8'(v));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
